/* File: ssc_params.svh */
// Purpose: Constants for the supervisor status register block.
// Assumes: Included by bare name from the package and the design.
// Notes:   Bit positions are the same in both register widths, apart from the dirty summary and the wide-only user width.
`ifndef SSC_PARAMS_SVH
`define SSC_PARAMS_SVH
`define SSC_ADDR_STATUS   4'h0
`define SSC_ADDR_MODE     4'h1
`define SSC_INT_EN_BIT    1
`define SSC_PREV_IE_BIT   5
`define SSC_USER_BE_BIT   6
`define SSC_PREV_PRIV_BIT 8
`define SSC_VEC_CTX_LO    9
`define SSC_FLT_CTX_LO    13
`define SSC_EXT_CTX_LO    15
`define SSC_USER_ACC_BIT  18
`define SSC_EXEC_RD_BIT   19
`define SSC_PREV_LP_BIT   23
`define SSC_TRAP_DIS_BIT  24
`define SSC_DIRTY32_BIT   31
`define SSC_UWIDTH_LO     32
`define SSC_DIRTY64_BIT   63
`define SSC_UWIDTH_32     2'h1
`define SSC_UWIDTH_64     2'h2
`define SSC_MASK_WIDE     64'h8000_0003_018c_6762
`define SSC_MASK_NARROW   64'h0000_0000_818c_6762
`define SSC_CTX_DIRTY     2'h3
`define SSC_RST_PRIV      1'h1
`define SSC_RST_BIT       1'h0
`define SSC_RST_CTX       2'h0
`define SSC_NARROW        32
`endif

/* File: ssc_pkg.sv */
// Purpose: Types shared by the supervisor status register block.
// Assumes: Nothing beyond the constants header.
// Notes:   Read data is held at the widest width and sliced by the module.
`include "ssc_params.svh"
package ssc_pkg;
    typedef struct packed {
        logic        priv;
        logic        sie;
        logic        prev_ie;
        logic        prev_priv;
        logic        user_be;
        logic        user_acc;
        logic        exec_rd;
        logic        prev_lp;
        logic        trap_dis;
        logic [1:0]  flt_ctx;
        logic [1:0]  vec_ctx;
        logic [1:0]  uwidth;
        logic [63:0] rdata;
    } ssc_state_t;
endpackage

/* File: ssc_status.sv */
// Purpose: Supervisor status register with trap entry, trap return and user width handling.
// Assumes: Trap and return pulses come from the hart sequencer, never both needed at once.
// Notes:   Address wrap and operand truncation are combinational datapath terms.
`timescale 1ns/1ns
`include "ssc_params.svh"
module ssc_status #(
    parameter int SUP_WIDTH = 64,
    parameter int NIRQ      = 16
) (
    input  wire logic                 MCLK_I,
    input  wire logic                 RST_N_I,
    input  wire logic [3:0]           ADDR_I,
    input  wire logic [SUP_WIDTH-1:0] WD_I,
    input  wire logic                 WE_I,
    input  wire logic                 RE_I,
    output logic      [SUP_WIDTH-1:0] RD_O,
    input  wire logic                 TRAP_I,
    input  wire logic                 TRAP_FROM_USER_I,
    input  wire logic                 TRAP_RET_I,
    output logic                      PRIV_SUP_O,
    input  wire logic [NIRQ-1:0]      INT_PEND_I,
    input  wire logic [NIRQ-1:0]      INT_MASK_I,
    output logic                      INT_TAKE_O,
    input  wire logic [SUP_WIDTH-1:0] OPERAND_I,
    output logic      [SUP_WIDTH-1:0] OPERAND_O,
    input  wire logic [SUP_WIDTH-1:0] RESULT_I,
    input  wire logic [SUP_WIDTH-1:0] DEST_OLD_I,
    input  wire logic                 HINT_I,
    output logic      [SUP_WIDTH-1:0] RESULT_O,
    input  wire logic [SUP_WIDTH-1:0] ADDR_EFF_I,
    output logic      [SUP_WIDTH-1:0] ADDR_EFF_O
);
    ssc_pkg::ssc_state_t st_r;
    ssc_pkg::ssc_state_t st_nxt;
    logic [63:0]         view;
    logic [63:0]         wd64;
    logic                dirty;
    logic                narrow;

    // Only the fields a supervisor may see are assembled; reserved bits stay zero.
    // The view is built at the widest width so that one read path serves both widths.
    // A narrow supervisor simply drops the upper half when the word leaves the block.
    always_comb begin
        dirty = (st_r.flt_ctx == `SSC_CTX_DIRTY) || (st_r.vec_ctx == `SSC_CTX_DIRTY); // Extra state is fixed clean.
        view = 64'h0;
        view[`SSC_INT_EN_BIT] = st_r.sie;
        view[`SSC_PREV_IE_BIT] = st_r.prev_ie;
        view[`SSC_USER_BE_BIT] = st_r.user_be;
        view[`SSC_PREV_PRIV_BIT] = st_r.prev_priv;
        view[`SSC_VEC_CTX_LO+:2] = st_r.vec_ctx;
        view[`SSC_FLT_CTX_LO+:2] = st_r.flt_ctx;
        view[`SSC_USER_ACC_BIT] = st_r.user_acc;
        view[`SSC_EXEC_RD_BIT] = st_r.exec_rd;
        view[`SSC_PREV_LP_BIT] = st_r.prev_lp;
        view[`SSC_TRAP_DIS_BIT] = st_r.trap_dis;
        if (SUP_WIDTH > `SSC_NARROW) begin
            view[`SSC_UWIDTH_LO+:2] = st_r.uwidth;
            view[`SSC_DIRTY64_BIT] = dirty;
        end else begin
            view[`SSC_DIRTY32_BIT] = dirty;
        end
        // Write data is widened once so field slices never run past a narrow bus.
        wd64 = 64'h0;
        wd64[SUP_WIDTH-1:0] = WD_I;
    end

    // Next state: software write first, then trap or return override it, so a hardware event is never lost.
    // Read data is captured here so that it stands for exactly one cycle after the strobe.
    always_comb begin
        st_nxt = st_r;
        st_nxt.rdata = 64'h0;
        if (RE_I && ADDR_I == `SSC_ADDR_STATUS) begin
            st_nxt.rdata = view;
        end else if (RE_I && ADDR_I == `SSC_ADDR_MODE) begin
            st_nxt.rdata[0] = st_r.priv; // Only user or supervisor is shown
        end
        if (WE_I && ADDR_I == `SSC_ADDR_STATUS) begin
            // Every field lands in the one shared copy a machine view would also use
            st_nxt.sie = wd64[`SSC_INT_EN_BIT];
            st_nxt.prev_ie = wd64[`SSC_PREV_IE_BIT];
            st_nxt.user_be = wd64[`SSC_USER_BE_BIT];
            st_nxt.prev_priv = wd64[`SSC_PREV_PRIV_BIT];
            st_nxt.vec_ctx = wd64[`SSC_VEC_CTX_LO+:2];
            st_nxt.flt_ctx = wd64[`SSC_FLT_CTX_LO+:2];
            st_nxt.user_acc = wd64[`SSC_USER_ACC_BIT];
            st_nxt.exec_rd = wd64[`SSC_EXEC_RD_BIT];
            st_nxt.prev_lp = wd64[`SSC_PREV_LP_BIT];
            st_nxt.trap_dis = wd64[`SSC_TRAP_DIS_BIT];
            // Only 32 and 64 bit codes are legal here; 128 and zero keep the old value
            if (SUP_WIDTH > `SSC_NARROW && (wd64[`SSC_UWIDTH_LO+:2] == `SSC_UWIDTH_32 ||
                                            wd64[`SSC_UWIDTH_LO+:2] == `SSC_UWIDTH_64)) begin
                st_nxt.uwidth = wd64[`SSC_UWIDTH_LO+:2];
            end
        end
        // Trap entry takes priority over a return in the same cycle; the sequencer never asks for both.
        if (TRAP_I) begin
            st_nxt.prev_priv = !TRAP_FROM_USER_I;
            st_nxt.prev_ie = st_r.sie;
            st_nxt.sie = 1'h0;
            st_nxt.priv = 1'h1;
        end else if (TRAP_RET_I) begin
            st_nxt.priv = st_r.prev_priv;
            st_nxt.prev_priv = 1'h0;
            st_nxt.sie = st_r.prev_ie;
            st_nxt.prev_ie = 1'h1;
        end
    end

    // All state lives in one registered copy.
    // Reset leaves the hart in supervisor mode with the widest legal user width.
    always_ff @(posedge MCLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            st_r.priv <= `SSC_RST_PRIV;
            st_r.sie <= `SSC_RST_BIT;
            st_r.prev_ie <= `SSC_RST_BIT;
            st_r.prev_priv <= `SSC_RST_BIT;
            st_r.user_be <= `SSC_RST_BIT;
            st_r.user_acc <= `SSC_RST_BIT;
            st_r.exec_rd <= `SSC_RST_BIT;
            st_r.prev_lp <= `SSC_RST_BIT;
            st_r.trap_dis <= `SSC_RST_BIT;
            st_r.flt_ctx <= `SSC_RST_CTX;
            st_r.vec_ctx <= `SSC_RST_CTX;
            st_r.uwidth <= (SUP_WIDTH > `SSC_NARROW) ? `SSC_UWIDTH_64 : 2'h0;
            st_r.rdata <= 64'h0;
        end else begin
            st_r <= st_nxt;
        end
    end

    // Global enable is forced on in user mode; each source still needs its own mask bit.
    // The take signal is combinational so that a mask change acts in the same cycle.
    always_comb begin
        INT_TAKE_O = (!st_r.priv || st_r.sie) && |(INT_PEND_I & INT_MASK_I);
        PRIV_SUP_O = st_r.priv;
        RD_O = st_r.rdata[SUP_WIDTH-1:0];
        narrow = (SUP_WIDTH > `SSC_NARROW) && !st_r.priv && st_r.uwidth == `SSC_UWIDTH_32;
    end

    // Width adaptation is only built when the supervisor is wider than the narrow mode.
    // Operands are zeroed above the narrow width, which is one legal way of ignoring them.
    // Addresses are wrapped by the same zeroing, so user code only reaches the low window.
    generate
        if (SUP_WIDTH > `SSC_NARROW) begin : g_wide
            always_comb begin
                OPERAND_O = OPERAND_I;
                ADDR_EFF_O = ADDR_EFF_I;
                RESULT_O = RESULT_I;
                if (narrow) begin
                    OPERAND_O = {{(SUP_WIDTH-`SSC_NARROW){1'b0}}, OPERAND_I[`SSC_NARROW-1:0]};
                    RESULT_O = {{(SUP_WIDTH-`SSC_NARROW){RESULT_I[`SSC_NARROW-1]}}, RESULT_I[`SSC_NARROW-1:0]};
                    ADDR_EFF_O = {{(SUP_WIDTH-`SSC_NARROW){1'b0}}, ADDR_EFF_I[`SSC_NARROW-1:0]};
                end
                // Skipping writeback keeps the hint cheap; upper bits are left as they were.
                if (narrow && HINT_I) begin
                    RESULT_O = DEST_OLD_I;
                end
            end
        end else begin : g_narrow
            always_comb begin
                OPERAND_O = OPERAND_I;
                ADDR_EFF_O = ADDR_EFF_I;
                RESULT_O = RESULT_I; // User width is always 32 here
            end
        end
    endgenerate

    // All checks below run on the one hart clock and are quiet while reset is low.
    default clocking cb @(posedge MCLK_I); endclocking
    default disable iff (!RST_N_I);

    // Steps the checks use are named once; only the return and status read steps are shared by several.
    sequence s_trap_user;
        TRAP_I && TRAP_FROM_USER_I;
    endsequence
    sequence s_ret_only;
        TRAP_RET_I && !TRAP_I;
    endsequence
    sequence s_read_status;
        RE_I && ADDR_I == `SSC_ADDR_STATUS;
    endsequence
    sequence s_read_mode;
        RE_I && ADDR_I == `SSC_ADDR_MODE;
    endsequence
    sequence s_write_plain;
        WE_I && ADDR_I == `SSC_ADDR_STATUS && !TRAP_I && !TRAP_RET_I;
    endsequence
    sequence s_write_bad_width;
        WE_I && ADDR_I == `SSC_ADDR_STATUS && !(wd64[`SSC_UWIDTH_LO+:2] inside {`SSC_UWIDTH_32, `SSC_UWIDTH_64});
    endsequence
    sequence s_write_good_width;
        WE_I && ADDR_I == `SSC_ADDR_STATUS && SUP_WIDTH > `SSC_NARROW &&
        wd64[`SSC_UWIDTH_LO+:2] inside {`SSC_UWIDTH_32, `SSC_UWIDTH_64};
    endsequence

    // Trap entry and return.
    a_trap_prev_user: assert property (s_trap_user |=> !st_r.prev_priv && st_r.priv)
        else $error("trap from user left previous privilege set");
    a_trap_prev_other: assert property (TRAP_I && !TRAP_FROM_USER_I |=> st_r.prev_priv)
        else $error("trap from supervisor left previous privilege clear");
    a_trap_priv: assert property (TRAP_I |=> PRIV_SUP_O)
        else $error("trap did not enter supervisor mode");
    a_ret_priv: assert property (s_ret_only |=> st_r.priv == $past(st_r.prev_priv) && !st_r.prev_priv)
        else $error("return chose wrong mode or kept previous privilege");
    a_trap_enable: assert property (TRAP_I |=> st_r.prev_ie == $past(st_r.sie) && !st_r.sie)
        else $error("trap did not stack the interrupt enable");
    a_ret_enable: assert property (s_ret_only |=> st_r.sie == $past(st_r.prev_ie) && st_r.prev_ie)
        else $error("return did not unstack the interrupt enable");

    // Interrupt gating.
    a_int_blocked: assert property (st_r.priv && !st_r.sie |-> !INT_TAKE_O)
        else $error("interrupt taken in supervisor with enable clear");
    a_user_masked: assert property (!(|(INT_PEND_I & INT_MASK_I)) |-> !INT_TAKE_O)
        else $error("interrupt taken with every source masked");
    a_user_enabled: assert property (!st_r.priv && |(INT_PEND_I & INT_MASK_I) |-> INT_TAKE_O)
        else $error("enabled interrupt not taken in user mode");

    // Register view and software writes.
    a_read_view: assert property (s_read_status |=> RD_O[`SSC_PREV_PRIV_BIT] == $past(st_r.prev_priv) &&
                                   RD_O[`SSC_INT_EN_BIT] == $past(st_r.sie))
        else $error("status read does not show the stored fields");
    a_read_dirty32: assert property (s_read_status |=> st_r.rdata[`SSC_DIRTY32_BIT] ==
                                      (SUP_WIDTH <= `SSC_NARROW && $past(dirty)))
        else $error("narrow dirty summary misplaced");
    a_read_dirty64: assert property (s_read_status |=> st_r.rdata[`SSC_DIRTY64_BIT] ==
                                      (SUP_WIDTH > `SSC_NARROW && $past(dirty)))
        else $error("wide dirty summary misplaced");
    a_read_width: assert property (s_read_status |=> st_r.rdata[`SSC_UWIDTH_LO+:2] ==
                                    ((SUP_WIDTH > `SSC_NARROW) ? $past(st_r.uwidth) : 2'h0))
        else $error("user width field not shown where expected");
    a_reserved_zero: assert property (s_read_status |=> (st_r.rdata & ~((SUP_WIDTH > `SSC_NARROW) ?
                                       `SSC_MASK_WIDE : `SSC_MASK_NARROW)) == 64'h0)
        else $error("reserved status bits read nonzero");
    a_mode_read: assert property (s_read_mode |=> st_r.rdata == {63'h0, $past(st_r.priv)})
        else $error("mode read shows more than user or supervisor");
    a_idle_read: assert property (!RE_I |=> st_r.rdata == 64'h0)
        else $error("read data present without a read");
    a_write_lands: assert property (s_write_plain |=> st_r.user_acc == $past(wd64[`SSC_USER_ACC_BIT]) &&
                                     st_r.exec_rd == $past(wd64[`SSC_EXEC_RD_BIT]) &&
                                     st_r.user_be == $past(wd64[`SSC_USER_BE_BIT]))
        else $error("software write did not reach the shared fields");
    a_width_legal: assert property (SUP_WIDTH > `SSC_NARROW |-> st_r.uwidth inside {`SSC_UWIDTH_32, `SSC_UWIDTH_64})
        else $error("user width field holds an illegal code");
    a_width_take: assert property (s_write_good_width |=> st_r.uwidth == $past(wd64[`SSC_UWIDTH_LO+:2]))
        else $error("legal user width write was lost");
    a_width_keep: assert property (s_write_bad_width |=> st_r.uwidth == $past(st_r.uwidth))
        else $error("illegal user width write changed the field");

    // Datapath width adaptation.
    a_narrow_user: assert property (narrow |-> !PRIV_SUP_O && SUP_WIDTH > `SSC_NARROW)
        else $error("narrow datapath active outside wide user mode");
    a_operand_trunc: assert property (narrow |-> OPERAND_O == {{(SUP_WIDTH-`SSC_NARROW){1'b0}},
                                       OPERAND_I[`SSC_NARROW-1:0]})
        else $error("narrow operand upper bits not ignored");
    a_result_sext: assert property (narrow && !HINT_I |-> RESULT_O ==
                                     {{(SUP_WIDTH-`SSC_NARROW){RESULT_I[`SSC_NARROW-1]}}, RESULT_I[`SSC_NARROW-1:0]})
        else $error("narrow result not sign-extended");
    a_wide_pass: assert property (!narrow |-> OPERAND_O == OPERAND_I && RESULT_O == RESULT_I &&
                                   ADDR_EFF_O == ADDR_EFF_I)
        else $error("full width datapath altered");
    a_hint_keep: assert property (narrow && HINT_I |-> RESULT_O == DEST_OLD_I)
        else $error("hint changed destination upper bits");
    a_addr_wrap: assert property (narrow |-> ADDR_EFF_O == {{(SUP_WIDTH-`SSC_NARROW){1'b0}},
                                   ADDR_EFF_I[`SSC_NARROW-1:0]})
        else $error("narrow user address not wrapped");
endmodule

/* File: ssc_hart_model.sv */
// Purpose: Hart sequencer model issuing trap and return pulses.
// Assumes: Requests are one-cycle pulses from the bench.
// Notes:   Pulses leave one cycle late, as a registered sequencer would.
`timescale 1ns/1ns
module ssc_hart_model (
    input  wire logic clk_i,
    input  wire logic rst_n_i,
    input  wire logic trap_req_i,
    input  wire logic ret_req_i,
    input  wire logic user_i,
    output logic      trap_o,
    output logic      ret_o,
    output logic      from_user_o
);
    // The origin flag means nothing outside a trap, so it toggles then.
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            trap_o      <= 1'b0;
            ret_o       <= 1'b0;
            from_user_o <= 1'b0;
        end else begin
            trap_o      <= trap_req_i;
            ret_o       <= ret_req_i;
            from_user_o <= trap_req_i ? user_i : ~from_user_o;
        end
    end
endmodule

/* File: testbench.sv */
// Purpose: Self-checking bench for the supervisor status register.
// Assumes: Wide supervisor width; the sequencer model drives trap and return.
// Notes:   Reads are compared against a queue of expected words.
`timescale 1ns/1ns
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin mismatches++; \
    $display("BAD %s exp %h got %h", n, e, g); end end
module testbench;
    logic        clk = 0, rst_n = 0, we = 0, re = 0, treq = 0, rreq = 0, usr = 0, hint = 0, rd_pend = 0, ps = 1;
    logic        trap, tret, fu, priv, itake;
    logic [3:0]  addr = 4'h0;
    logic [15:0] pend = 16'h0, msk = 16'h0;
    logic [63:0] wd = 64'h0, op = 64'h0, res = 64'h0, dold = 64'h0, aeff = 64'h0;
    logic [63:0] rdo, op_o, res_o, aeff_o, e, img = 64'h2_0000_0000;
    logic [63:0] q[$];
    int          mismatches = 0, num_checks = 0;
    ssc_status #(.SUP_WIDTH(64), .NIRQ(16)) ssc_status_inst (.MCLK_I(clk), .RST_N_I(rst_n), .ADDR_I(addr),
        .WD_I(wd), .WE_I(we), .RE_I(re), .RD_O(rdo), .TRAP_I(trap), .TRAP_FROM_USER_I(fu), .TRAP_RET_I(tret),
        .PRIV_SUP_O(priv), .INT_PEND_I(pend), .INT_MASK_I(msk), .INT_TAKE_O(itake), .OPERAND_I(op),
        .OPERAND_O(op_o), .RESULT_I(res), .DEST_OLD_I(dold), .HINT_I(hint), .RESULT_O(res_o),
        .ADDR_EFF_I(aeff), .ADDR_EFF_O(aeff_o));
    ssc_hart_model ssc_hart_model_inst (.clk_i(clk), .rst_n_i(rst_n), .trap_req_i(treq), .ret_req_i(rreq),
        .user_i(usr), .trap_o(trap), .ret_o(tret), .from_user_o(fu));
    // Free-running clock at 25 MHz.
    initial forever #20 clk = ~clk;
    // Read view of the shadow image; the summary bit follows float or vector dirty.
    function automatic logic [63:0] view(input logic [63:0] s);
        return {s[14:13] == 2'h3 || s[10:9] == 2'h3, s[62:0]};
    endfunction
    task automatic wr(input logic [3:0] a, input logic [63:0] d);
        @(posedge clk);
        addr <= a;
        wd   <= d;
        we   <= 1'b1;
        @(posedge clk);
        we   <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, input logic [63:0] x);
        @(posedge clk);
        addr <= a;
        re   <= 1'b1;
        q.push_back(x);
        @(posedge clk);
        re   <= 1'b0;
    endtask
    // Trap (t=1) or return, with the origin taken from the current mode.
    task automatic ev(input logic t);
        @(posedge clk);
        treq <= t;
        rreq <= ~t;
        usr  <= ~ps;
        @(posedge clk);
        treq <= 1'b0;
        rreq <= 1'b0;
        repeat (2) @(posedge clk);
        if (t) begin
            img[5] = img[1];
            img[1] = 1'b0;
            img[8] = ~usr;
            ps     = 1'b1;
        end else begin
            ps     = img[8];
            img[8] = 1'b0;
            img[1] = img[5];
            img[5] = 1'b1;
        end
        @(negedge clk);
        `CHK("priv", ps, priv)
    endtask
    // Random datapath and interrupt inputs, checked in the same cycle.
    task automatic dp();
        logic nar;
        nar = !ps && img[33:32] == 2'h1;
        @(posedge clk);
        op   <= {$urandom, $urandom};
        res  <= {$urandom, $urandom};
        dold <= {$urandom, $urandom};
        aeff <= {$urandom, $urandom};
        pend <= 16'($urandom);
        msk  <= 16'($urandom);
        hint <= 1'($urandom);
        @(negedge clk);
        `CHK("op", nar ? {32'h0, op[31:0]} : op, op_o)
        `CHK("addr", nar ? {32'h0, aeff[31:0]} : aeff, aeff_o)
        `CHK("res", !nar ? res : hint ? dold : {{32{res[31]}}, res[31:0]}, res_o)
        `CHK("int", |(pend & msk) && (!ps || img[1]), itake)
    endtask
    // Read data is due one edge after the strobe and must be zero otherwise.
    always @(posedge clk) rd_pend <= re;
    always @(negedge clk) begin
        if (rd_pend) begin
            e = q.pop_front();
            `CHK("rd", e, rdo)
        end else
            `CHK("rd idle", 64'h0, rdo)
    end
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    // A hang counts as a mismatch.
    initial begin
        repeat (20000) @(posedge clk);
        mismatches++;
        give_verdict();
    end
    // Main sequence: reset view, refused writes, field writes, then traps and returns.
    initial begin
        logic [63:0] d;
        void'($urandom(32'h9426af11));
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        rd(4'h0, view(img));
        rd(4'hf, 64'h0);
        wr(4'hf, '1);
        wr(4'h1, 64'h0);
        rd(4'h1, 64'h1);
        for (int i = 0; i < 8; i++) begin
            d = {$urandom, $urandom};
            d[24] = 1'b0;
            d[33:32] = 2'(i + 2);
            wr(4'h0, d);
            img = {30'h0, (d[33:32] == 2'h1 || d[33:32] == 2'h2) ? d[33:32] : img[33:32], d[31:0] & 32'h018c_6762};
            rd(4'h0, view(img));
            dp();
        end
        for (int i = 0; i < 16; i++) begin
            ev(1'($urandom));
            rd(4'h0, view(img));
            rd(4'h1, {63'h0, ps});
            dp();
        end
        give_verdict();
    end
endmodule
